// [rtl/nesr_top.sv]
// Command sequencer for block erase, status read, ID read, reset and ready/busy.
`timescale 1ns/1ps
`include "nesr_regs.svh"
// Behaviour
// - Erase starts with setup command 60h then two block address cycles.
// - Erasing begins only when confirm D0h follows the address load.
// - Block address is A14 to A24; A9 to A13 are ignored.
// - After confirm the erase runs and posts pass or fail in bit 0.
// - After 70h each read cycle drives status once chip-select and read-strobe are low.
// - Status on the pins follows updates without new strobes.
// - Status bit 0 is 0 on success, 1 on failure.
// - Status bits 1 to 5 always read 0.
// - Status bit 6 is 0 while busy, 1 when ready.
// - Status bit 7 is 0 when write protected, 1 otherwise.
// - Command 90h plus address 00h gives maker then device code.
// - Identification mode holds until a new command is written.
// - Command FFh resets and aborts an erase in progress.
// - Reset clears the command state; status becomes C0h with protect high.
// - A reset command during reset is ignored.
// - Ready/busy goes low for the reset busy time after FFh.
// - Power-up leaves main read mode; reset leaves waiting for a command.
// - Ready/busy goes low on accepted erase and releases when it ends.
// - While busy only status read and reset commands are accepted.
module nesr_top import nesr_pkg::*; #(
	parameter int ERASE_CYCLES = `NESR_ERASE_CYCLES,
	parameter logic [7:0] MAKER_CODE = 8'h5a,
	parameter logic [7:0] DEVICE_CODE = 8'ha5
) (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic CE_N,
	input wire logic CLE,
	input wire logic ALE,
	input wire logic WE_N,
	input wire logic READ_STROBE_N,
	input wire logic WP_N,
	input wire logic [7:0] IO_IN,
	input wire logic ERASE_FAULT,
	output logic [7:0] IO_OUT,
	output logic IO_OE_N,
	output logic RB_OUT,
	output logic RB_OE_N,
	output logic [10:0] ERASE_BLOCK,
	output logic ERASE_ACTIVE,
	output logic ERASE_ABORT,
	output logic [1:0] MODE
);
	localparam logic [15:0] RST_LOAD = 16'(`NESR_RST_CYCLES);
	localparam logic [15:0] ERASE_LOAD = 16'(ERASE_CYCLES);

	nesr_seq_t seq, next_seq;
	nesr_mode_t mode, next_mode;
	nesr_op_t op, next_op;
	logic we_q, re_q;
	logic fail, next_fail;
	logic [2:0] blk_lo, next_blk_lo;
	logic [7:0] blk_hi, next_blk_hi;
	logic [1:0] id_idx, next_id_idx;
	logic tmr_start, tmr_abort, tmr_busy, tmr_done;
	logic [15:0] tmr_load;
	logic [7:0] id_data;
	logic [7:0] status;
	logic we_rise, re_rise, cmd_wr, adr_wr, next_busy, rd_active;
	logic [7:0] next_io_out;
	logic next_io_oe_n, next_abort;

	nesr_busy_timer #(.W(16)) u_timer (
		.clk(SYS_CLK),
		.srst(SRST),
		.start(tmr_start),
		.load(tmr_load),
		.abort(tmr_abort),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	nesr_id_rom #(.MAKER_CODE(MAKER_CODE), .DEVICE_CODE(DEVICE_CODE)) u_id (
		.clk(SYS_CLK),
		.srst(SRST),
		.addr(id_idx),
		.data(id_data)
	);

	assign we_rise = ~we_q & WE_N & ~CE_N;
	assign re_rise = ~re_q & READ_STROBE_N & ~CE_N;
	assign cmd_wr = we_rise & CLE & ~ALE;
	assign adr_wr = we_rise & ALE & ~CLE;
	// Live status byte with reserved bits held at zero.
	assign status = {WP_N, ~tmr_busy, 5'h00, fail};

	always_comb begin
		next_seq = seq;
		next_mode = mode;
		next_op = op;
		next_fail = fail;
		next_blk_lo = blk_lo;
		next_blk_hi = blk_hi;
		next_id_idx = id_idx;
		next_abort = 1'b0;
		tmr_start = 1'b0;
		tmr_abort = 1'b0;
		tmr_load = 16'h0000;
		if (tmr_done) begin
			if (op == OP_ERASE) begin
				next_fail = ERASE_FAULT;
			end
			next_op = OP_NONE;
		end
		if (cmd_wr) begin
			if (IO_IN == `NESR_CMD_RESET) begin
				if (op != OP_RESET) begin
					next_abort = (op == OP_ERASE);
					next_op = OP_RESET;
					next_fail = 1'b0;
					next_mode = MD_WAIT;
					next_seq = SQ_IDLE;
					tmr_start = 1'b1;
					tmr_load = RST_LOAD;
				end
			end else if (IO_IN == `NESR_CMD_STATUS) begin
				next_mode = MD_STATUS;
				next_seq = SQ_IDLE;
			end else if (!tmr_busy) begin
				next_seq = SQ_IDLE;
				unique case (IO_IN)
					`NESR_CMD_ERASE_SETUP: begin
						next_seq = SQ_ERA_A1;
						next_mode = MD_WAIT;
					end
					`NESR_CMD_ERASE_CONFIRM: begin
						if (seq == SQ_ERA_CF && WP_N) begin
							next_op = OP_ERASE;
							tmr_start = 1'b1;
							tmr_load = ERASE_LOAD;
						end
						next_mode = MD_WAIT;
					end
					`NESR_CMD_READ1, `NESR_CMD_READ2: begin
						next_mode = MD_READ1;
					end
					`NESR_CMD_READ_ID: begin
						next_seq = SQ_ID_ADDR;
						next_mode = MD_WAIT;
					end
					default: begin
						next_mode = MD_WAIT;
					end
				endcase
			end
		end else if (adr_wr && !tmr_busy) begin
			unique case (seq)
				SQ_ERA_A1: begin
					next_blk_lo = IO_IN[`NESR_ERASE_LO_MSB:`NESR_ERASE_LO_LSB];
					next_seq = SQ_ERA_A2;
				end
				SQ_ERA_A2: begin
					next_blk_hi = IO_IN;
					next_seq = SQ_ERA_CF;
				end
				SQ_ID_ADDR: begin
					if (IO_IN == `NESR_ID_ADDR) begin
						next_mode = MD_ID;
						next_id_idx = 2'h0;
					end
					next_seq = SQ_IDLE;
				end
				SQ_IDLE, SQ_ERA_CF: begin
					next_seq = SQ_IDLE;
				end
				default: begin
					next_seq = SQ_IDLE;
				end
			endcase
		end else if (re_rise && mode == MD_ID && id_idx != 2'h2) begin
			next_id_idx = id_idx + 2'h1;
		end
	end

	always_comb begin
		next_busy = tmr_start | (tmr_busy & ~tmr_done);
		rd_active = ~CE_N & ~READ_STROBE_N;
		next_io_oe_n = 1'b1;
		next_io_out = 8'h00;
		if (rd_active && mode == MD_STATUS) begin
			next_io_oe_n = 1'b0;
			next_io_out = status;
		end else if (rd_active && mode == MD_ID) begin
			next_io_oe_n = 1'b0;
			next_io_out = id_data;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			seq <= SQ_IDLE;
			mode <= MD_READ1;
			op <= OP_NONE;
			fail <= 1'b0;
			blk_lo <= 3'h0;
			blk_hi <= 8'h00;
			id_idx <= 2'h0;
			we_q <= 1'b1;
			re_q <= 1'b1;
			IO_OUT <= 8'h00;
			IO_OE_N <= 1'b1;
			RB_OUT <= 1'b0;
			RB_OE_N <= 1'b1;
			ERASE_BLOCK <= 11'h000;
			ERASE_ACTIVE <= 1'b0;
			ERASE_ABORT <= 1'b0;
			MODE <= 2'h0;
		end else begin
			seq <= next_seq;
			mode <= next_mode;
			op <= next_op;
			fail <= next_fail;
			blk_lo <= next_blk_lo;
			blk_hi <= next_blk_hi;
			id_idx <= next_id_idx;
			we_q <= WE_N;
			re_q <= READ_STROBE_N;
			IO_OUT <= next_io_out;
			IO_OE_N <= next_io_oe_n;
			RB_OUT <= 1'b0;
			RB_OE_N <= ~next_busy;
			ERASE_BLOCK <= {next_blk_hi, next_blk_lo};
			ERASE_ACTIVE <= (next_op == OP_ERASE);
			ERASE_ABORT <= next_abort;
			MODE <= next_mode;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	property p_erase_needs_confirm;
		$rose(ERASE_ACTIVE) |-> $past(seq) == SQ_ERA_CF && $past(cmd_wr) && $past(IO_IN) == `NESR_CMD_ERASE_CONFIRM;
	endproperty
	a_erase_needs_confirm: assert property (p_erase_needs_confirm) else $error("erase without confirm");

	property p_erase_busy;
		$rose(ERASE_ACTIVE) |-> !RB_OE_N;
	endproperty
	a_erase_busy: assert property (p_erase_busy) else $error("busy not shown on erase");

	property p_reserved_zero;
		!IO_OE_N && MODE == MD_STATUS |-> IO_OUT[5:1] == 5'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits set");

	property p_status_out;
		MODE == MD_STATUS && !CE_N && !READ_STROBE_N && !cmd_wr |=> !IO_OE_N;
	endproperty
	a_status_out: assert property (p_status_out) else $error("status not driven");

	property p_status_live;
		!IO_OE_N && $past(MODE) == MD_STATUS && $past(rd_active) |-> IO_OUT[6] == $past(~tmr_busy) && IO_OUT[7] == $past(WP_N);
	endproperty
	a_status_live: assert property (p_status_live) else $error("status not live");

	property p_reset_busy;
		cmd_wr && IO_IN == `NESR_CMD_RESET && op != OP_RESET |=> !RB_OE_N [*8];
	endproperty
	a_reset_busy: assert property (p_reset_busy) else $error("reset busy too short");

	property p_reset_ignored;
		cmd_wr && IO_IN == `NESR_CMD_RESET && op == OP_RESET |=> op == OP_RESET && !tmr_start;
	endproperty
	a_reset_ignored: assert property (p_reset_ignored) else $error("reset restarted");

	property p_reset_aborts;
		cmd_wr && IO_IN == `NESR_CMD_RESET && op == OP_ERASE |=> ERASE_ABORT && !ERASE_ACTIVE && MODE == MD_WAIT;
	endproperty
	a_reset_aborts: assert property (p_reset_aborts) else $error("erase not aborted");

	property p_busy_filter;
		tmr_busy && cmd_wr && IO_IN == `NESR_CMD_READ_ID |=> seq != SQ_ID_ADDR;
	endproperty
	a_busy_filter: assert property (p_busy_filter) else $error("command taken while busy");

	property p_fail_post;
		tmr_done && op == OP_ERASE |=> fail == $past(ERASE_FAULT);
	endproperty
	a_fail_post: assert property (p_fail_post) else $error("erase result lost");

	property p_protect_blocks_erase;
		cmd_wr && IO_IN == `NESR_CMD_ERASE_CONFIRM && !WP_N && !tmr_busy |=> !ERASE_ACTIVE && RB_OE_N;
	endproperty
	a_protect_blocks_erase: assert property (p_protect_blocks_erase) else $error("erase while protected");

	property p_id_advance;
		re_rise && mode == MD_ID && id_idx == 2'h0 && !cmd_wr && !adr_wr |=> id_idx == 2'h1;
	endproperty
	a_id_advance: assert property (p_id_advance) else $error("id index stuck");

	property p_reset_status;
		tmr_done && op == OP_RESET && WP_N ##1 WP_N |-> status == `NESR_STAT_RESET;
	endproperty
	a_reset_status: assert property (p_reset_status) else $error("status wrong after reset");

	c_erase_done: cover property (ERASE_ACTIVE ##1 !ERASE_ACTIVE && !ERASE_ABORT);
	c_reset_abort: cover property (ERASE_ABORT);
	c_id_device: cover property (MODE == MD_ID && !IO_OE_N && IO_OUT == DEVICE_CODE);
	c_status_read: cover property (MODE == MD_STATUS && !IO_OE_N);
endmodule : nesr_top

// [rtl/nesr_regs.svh]
// Constants of the NAND erase, status, ID and reset sequencer.
`ifndef NESR_REGS_SVH
`define NESR_REGS_SVH
`define NESR_CMD_READ1 8'h00
`define NESR_CMD_READ2 8'h50
`define NESR_CMD_ERASE_SETUP 8'h60
`define NESR_CMD_ERASE_CONFIRM 8'hd0
`define NESR_CMD_STATUS 8'h70
`define NESR_CMD_READ_ID 8'h90
`define NESR_CMD_RESET 8'hff
`define NESR_ID_ADDR 8'h00
`define NESR_STAT_FAIL_BIT 0
`define NESR_STAT_READY_BIT 6
`define NESR_STAT_WP_BIT 7
`define NESR_STAT_RESET 8'hc0
`define NESR_ERASE_LO_MSB 7
`define NESR_ERASE_LO_LSB 5
`define NESR_CLK_NS 50
`define NESR_RST_TIME_NS 5000
`define NESR_ERASE_TIME_NS 2000000
`define NESR_RST_CYCLES ((`NESR_RST_TIME_NS + `NESR_CLK_NS - 1) / `NESR_CLK_NS)
`define NESR_ERASE_CYCLES (`NESR_ERASE_TIME_NS / `NESR_CLK_NS)
`endif

// [rtl/nesr_pkg.sv]
// Types of the NAND erase, status, ID and reset sequencer.
package nesr_pkg;
	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000,
		SQ_ERA_A1 = 3'b001,
		SQ_ERA_A2 = 3'b010,
		SQ_ERA_CF = 3'b011,
		SQ_ID_ADDR = 3'b100
	} nesr_seq_t;
	typedef enum logic [1:0] {
		MD_READ1 = 2'b00,
		MD_WAIT = 2'b01,
		MD_STATUS = 2'b10,
		MD_ID = 2'b11
	} nesr_mode_t;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_ERASE = 2'b01,
		OP_RESET = 2'b10
	} nesr_op_t;
endpackage : nesr_pkg

// [rtl/nesr_busy_timer.sv]
// Down counter that times an internal busy period.
`timescale 1ns/1ps
module nesr_busy_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [W-1:0] load,
	input wire logic abort,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_busy;

	assign done = busy & (cnt == {{(W-1){1'b0}}, 1'b1}) & ~start & ~abort;

	always_comb begin
		next_cnt = cnt;
		next_busy = busy;
		if (start) begin
			next_cnt = load;
			next_busy = 1'b1;
		end else if (abort || done) begin
			next_busy = 1'b0;
			next_cnt = '0;
		end else if (busy) begin
			next_cnt = cnt - {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt <= '0;
			busy <= 1'b0;
		end else begin
			cnt <= next_cnt;
			busy <= next_busy;
		end
	end
endmodule : nesr_busy_timer

// [rtl/nesr_id_rom.sv]
// Identification table with registered read data.
`timescale 1ns/1ps
module nesr_id_rom #(
	parameter logic [7:0] MAKER_CODE = 8'h5a,
	parameter logic [7:0] DEVICE_CODE = 8'ha5
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [1:0] addr,
	output logic [7:0] data
);
	logic [7:0] next_data;

	always_comb begin
		unique case (addr)
			2'h0: next_data = MAKER_CODE;
			2'h1: next_data = DEVICE_CODE;
			2'h2, 2'h3: next_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			data <= 8'h00;
		end else begin
			data <= next_data;
		end
	end
endmodule : nesr_id_rom

// [tb/nesr_ctrl_model.sv]
// Controller model that drives the flash command port.
`timescale 1ns/1ps
module nesr_ctrl_model (
	input wire logic sys_clk,
	input wire logic rb_oe_n,
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic read_strobe_n,
	output logic wp_n,
	output logic [7:0] io_in
);
	initial begin
		ce_n = 1'b1;
		cle = 1'b0;
		ale = 1'b0;
		we_n = 1'b1;
		read_strobe_n = 1'b1;
		wp_n = 1'b0;
		io_in = 8'h00;
	end
	task automatic wp(input logic v);
		@(posedge sys_clk);
		#5 wp_n = v;
	endtask : wp
	task automatic power_up();
		repeat (200) @(posedge sys_clk);
		wp(1'b1);
	endtask : power_up
	task automatic wr(input logic is_cmd, input logic [7:0] b, input logic rdy);
		int n;
		n = 0;
		while (rdy && rb_oe_n !== 1'b1 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		#5 ce_n = 1'b0;
		cle = is_cmd;
		ale = !is_cmd;
		io_in = b;
		we_n = 1'b0;
		@(posedge sys_clk);
		#5 we_n = 1'b1;
		@(posedge sys_clk);
		#5 cle = 1'b0;
		ale = 1'b0;
		ce_n = 1'b1;
		io_in = ~b;
	endtask : wr
	task automatic rd(input logic on);
		@(posedge sys_clk);
		#5 read_strobe_n = !on;
		if (on) begin
			ce_n = 1'b0;
		end else begin
			@(posedge sys_clk);
			#5 ce_n = 1'b1;
		end
	endtask : rd
endmodule : nesr_ctrl_model

// [tb/nesr_top_tb_top.sv]
// Self-checking testbench of the NAND erase, status, ID and reset sequencer.
`timescale 1ns/1ps
module nesr_top_tb_top;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic erase_fault = 1'b0;
	logic ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe_n, rb_out, rb_oe_n, erase_active, erase_abort;
	logic [7:0] io_in, io_out;
	logic [10:0] erase_block;
	logic [1:0] mode;
	int miscompares = 0;
	int n_tests = 0;
	int n;
	always #25 sys_clk = ~sys_clk;
	nesr_top #(.ERASE_CYCLES(20)) nesr_top_i (.SYS_CLK(sys_clk), .SRST(srst), .CE_N(ce_n), .CLE(cle), .ALE(ale),
		.WE_N(we_n), .READ_STROBE_N(read_strobe_n), .WP_N(wp_n), .IO_IN(io_in), .ERASE_FAULT(erase_fault),
		.IO_OUT(io_out), .IO_OE_N(io_oe_n), .RB_OUT(rb_out), .RB_OE_N(rb_oe_n), .ERASE_BLOCK(erase_block),
		.ERASE_ACTIVE(erase_active), .ERASE_ABORT(erase_abort), .MODE(mode));
	nesr_ctrl_model nesr_ctrl_model_i (.sys_clk(sys_clk), .rb_oe_n(rb_oe_n), .ce_n(ce_n), .cle(cle), .ale(ale),
		.we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_in(io_in));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rd(input logic [7:0] exp, input string what);
		nesr_ctrl_model_i.rd(1'b1);
		repeat (2) @(posedge sys_clk);
		#1 chk("output enable", 11'h0, io_oe_n);
		chk(what, exp, io_out);
		nesr_ctrl_model_i.rd(1'b0);
		repeat (2) @(posedge sys_clk);
	endtask : rd
	task automatic busy_len();
		n = 0;
		while (rb_oe_n !== 1'b1 && n < 500) begin
			@(posedge sys_clk);
			#1 n++;
		end
		if (n >= 500) begin
			miscompares++;
			$display("mismatch busy end expected ready seen busy");
		end
	endtask : busy_len
	task automatic erase(input logic [7:0] a2);
		nesr_ctrl_model_i.wr(1'b1, 8'h60, 1'b1);
		nesr_ctrl_model_i.wr(1'b0, 8'he3, 1'b1);
		nesr_ctrl_model_i.wr(1'b0, a2, 1'b1);
		nesr_ctrl_model_i.wr(1'b1, 8'hd0, 1'b1);
		chk("busy on confirm", 11'h0, rb_oe_n);
		chk("open-drain level", 11'h0, rb_out);
		chk("erase running", 11'h1, erase_active);
		chk("block", {a2, 3'b111}, erase_block);
	endtask : erase
	initial begin
		repeat (20) @(posedge sys_clk);
		#5 srst = 1'b0;
		chk("mode after power-up", 11'h0, mode);
		nesr_ctrl_model_i.power_up();
		nesr_ctrl_model_i.wr(1'b1, 8'h70, 1'b0);
		rd(8'hc0, "status idle");
		nesr_ctrl_model_i.wp(1'b0);
		rd(8'h40, "status protected");
		nesr_ctrl_model_i.wp(1'b1);
		$display("test status done");
		erase_fault = 1'b1;
		erase(8'h5a);
		nesr_ctrl_model_i.wr(1'b1, 8'h90, 1'b0);
		chk("id refused while busy", 11'h0, mode == 2'd3);
		nesr_ctrl_model_i.wr(1'b1, 8'h70, 1'b0);
		nesr_ctrl_model_i.rd(1'b1);
		repeat (2) @(posedge sys_clk);
		#1 chk("status busy", 11'h80, io_out);
		busy_len();
		repeat (2) @(posedge sys_clk);
		#1 chk("status failed", 11'hc1, io_out);
		nesr_ctrl_model_i.rd(1'b0);
		repeat (2) @(posedge sys_clk);
		$display("test erase fail done");
		nesr_ctrl_model_i.wr(1'b1, 8'h60, 1'b1);
		nesr_ctrl_model_i.wr(1'b0, 8'he3, 1'b1);
		nesr_ctrl_model_i.wr(1'b0, 8'h5a, 1'b1);
		nesr_ctrl_model_i.wr(1'b1, 8'h70, 1'b0);
		nesr_ctrl_model_i.wr(1'b1, 8'hd0, 1'b1);
		chk("no erase after break", 11'h0, erase_active);
		chk("ready after break", 11'h1, rb_oe_n);
		$display("test broken sequence done");
		nesr_ctrl_model_i.wp(1'b0);
		nesr_ctrl_model_i.wr(1'b1, 8'h60, 1'b1);
		nesr_ctrl_model_i.wr(1'b0, 8'he3, 1'b1);
		nesr_ctrl_model_i.wr(1'b0, 8'h5a, 1'b1);
		nesr_ctrl_model_i.wr(1'b1, 8'hd0, 1'b1);
		chk("no erase protected", 11'h0, erase_active);
		chk("ready protected", 11'h1, rb_oe_n);
		nesr_ctrl_model_i.wp(1'b1);
		$display("test protected erase done");
		erase(8'h01);
		nesr_ctrl_model_i.wr(1'b1, 8'hff, 1'b0);
		chk("abort pulse", 11'h1, erase_abort);
		chk("erase stopped", 11'h0, erase_active);
		chk("mode after reset", 11'h1, mode);
		chk("busy on reset", 11'h0, rb_oe_n);
		nesr_ctrl_model_i.wr(1'b1, 8'hff, 1'b0);
		busy_len();
		chk("reset busy length", 11'h1, n >= 95 && n <= 99);
		chk("mode waiting", 11'h1, mode);
		nesr_ctrl_model_i.wr(1'b1, 8'h70, 1'b0);
		rd(8'hc0, "status after reset");
		$display("test reset done");
		#5 erase_fault = 1'b0;
		erase(8'hff);
		busy_len();
		nesr_ctrl_model_i.wr(1'b1, 8'h70, 1'b0);
		rd(8'hc0, "status passed");
		$display("test erase pass done");
		nesr_ctrl_model_i.wr(1'b1, 8'h90, 1'b1);
		nesr_ctrl_model_i.wr(1'b0, 8'h00, 1'b1);
		rd(8'h5a, "maker code");
		rd(8'ha5, "device code");
		chk("id mode held", 11'h3, mode);
		nesr_ctrl_model_i.wr(1'b1, 8'h00, 1'b1);
		chk("read mode", 11'h0, mode);
		nesr_ctrl_model_i.wr(1'b1, 8'h70, 1'b0);
		chk("status mode", 11'h2, mode);
		nesr_ctrl_model_i.wr(1'b1, 8'h50, 1'b1);
		chk("read mode after 50h", 11'h0, mode);
		$display("test id done");
		end_of_test();
	end
	initial begin
		#(20000 * 50);
		miscompares++;
		end_of_test();
	end
endmodule : nesr_top_tb_top
